// ### src/asp_pkg.sv
// Constants shared by the two-mode converter serial port
package asp_pkg;
   // Word and register file shape
   localparam int WORD_BITS = 16;
   localparam int REG_COUNT = 14;
   localparam int REG_W = 14;
   localparam int WDATA_W = 12;
   // Register addresses carried in the top nibble of a write word
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_RESULT = 4'hc;
   localparam logic [3:0] ADDR_STATUS = 4'hd;
   localparam int WADDR_LSB = 12;
   // Control register fields
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_TWO_WIRE_BIT = 1;
   localparam int CTRL_SEL_LSB = 2;
   localparam int CTRL_BURST_LSB = 6;
   localparam logic [REG_W-1:0] CTRL_RESET = 14'h0000;
   // Status register fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_CAL_BIT = 1;
   // Timing: clock period, conversion time, power-on calibration time
   localparam int CLK_PERIOD_PS = 5000;
   localparam int CONV_TIME_NS = 3500;
   localparam int CONV_CYCLES = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam int CAL_TIME_MS = 150;
   localparam int CAL_CYCLES = int'((64'(CAL_TIME_MS) * 64'd1000000000) / 64'(CLK_PERIOD_PS));
endpackage : asp_pkg

// ### src/asp_top.sv
// Serial control and data port of the sampling converter, two-wire and three-wire modes
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Conversion starts on conv_start_n pulse or control start bit written one.
// - Two-wire frame select is active-low level, pulsed or held low.
// - Two-wire pulsed: sample on rising edges, line turns output after sixteenth.
// - Line floats while frame select high; driven once it falls.
// - After sixteen read clocks line reverts to input after dir_revert_delay.
// - Select held low: line never floats, direction flips every sixteenth edge.
// - Calibration burst stays one direction for all selected words, no abort.
// - After reset the port runs in three-wire mode.
// - Three-wire: select low enables output, released out_release_delay after high.
// - Three-wire: input bits captured on rising shift-clock edge.
// - Select high then low resets the serial interface.
// - Fourteen internal registers readable by serial reads; serial writes reach only the twelve below the result register.
// - Power-on calibration on the master clock, about 150 ms.
// - Two-wire reads and writes alternate; three-wire does both at once.
// - An all-zero write word changes no register.
// - Status busy bit reads zero once conversion has ended.
// - Conversion completes within its fixed conversion time.
// - Select falling with clock low presents the MSB at once.
// - Select high clears the shift register; next word starts fresh.
module asp_top #(
   parameter int CAL_CYCLES = asp_pkg::CAL_CYCLES
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic sclk_i,
   input wire logic frame_select_n_i,
   input wire logic serial_in_i,
   output logic serial_in_o,
   output logic serial_in_oe_o,
   output logic serial_out_o,
   output logic serial_out_oe_o,
   input wire logic conv_start_n_i,
   input wire logic [asp_pkg::REG_W-1:0] adc_data_i,
   output logic busy_o
);
   import asp_pkg::*;

   // One timer serves calibration and conversion, so it is sized for the longer count
   localparam int TW = $clog2(((CAL_CYCLES > CONV_CYCLES) ? CAL_CYCLES : CONV_CYCLES) + 1);
   localparam int CONV_LAST = CONV_CYCLES - 1;

   // Link state kept across frames, cleared only by the system reset
   typedef struct packed {
      logic [1:0] tw_sync;
      logic [1:0][2:0] burst_sync;
      logic dir;
      logic [2:0] bcnt;
      logic rx_tgl;
      logic [WORD_BITS-1:0] rx_word;
   } asp_link_t;

   // Link state of the current frame, cleared while select is high
   typedef struct packed {
      logic [3:0] cnt;
      logic [WORD_BITS-2:0] shift;
   } asp_frame_t;

   // Master clock state
   typedef struct packed {
      logic [1:0] fs_sync;
      logic [1:0] cs_sync;
      logic cs_last;
      logic [1:0] tgl_sync;
      logic tgl_last;
      logic [1:0] dir_sync;
      logic [REG_COUNT-1:0][REG_W-1:0] regs;
      logic [WORD_BITS-1:0] tx;
      logic busy;
      logic cal;
      logic [TW-1:0] timer;
      logic oe_in;
      logic oe_out;
   } asp_sys_t;

   asp_link_t lk_q, lk_d;
   asp_frame_t fr_q, fr_d;
   asp_sys_t st_q, st_d;
   logic out_q;
   logic frame_rst;
   logic two_wire;
   logic receiving;
   logic word_end;
   logic [WORD_BITS-1:0] full_word;

   // Select high acts as an asynchronous reset of the frame logic; a lost
   // word is recovered simply by raising select, whatever the bit count
   // level-sensitive select
   assign frame_rst = rst_i | frame_select_n_i;
   assign two_wire = lk_q.tw_sync[1];
   assign receiving = ~two_wire | ~lk_q.dir;
   assign word_end = fr_q.cnt == 4'hf;
   assign full_word = {fr_q.shift, serial_in_i};

   // Link next state on rising shift-clock edges
   always_comb begin
      lk_d = lk_q;
      fr_d = fr_q;
      // Mode and burst length are quasi-static, so a plain two-stage sync suffices
      lk_d.tw_sync = {lk_q.tw_sync[0], st_q.regs[ADDR_CTRL][CTRL_TWO_WIRE_BIT]};
      lk_d.burst_sync = {lk_q.burst_sync[0], st_q.regs[ADDR_CTRL][CTRL_BURST_LSB +: 3]};
      fr_d.cnt = fr_q.cnt + 4'h1;
      if (receiving) begin
         fr_d.shift = full_word[WORD_BITS-2:0];
      end
      if (word_end) begin
         if (receiving) begin
            lk_d.rx_word = full_word;
            lk_d.rx_tgl = ~lk_q.rx_tgl;
         end
         if (two_wire) begin
            if (lk_q.bcnt != 3'h0) begin
               lk_d.bcnt = lk_q.bcnt - 3'h1;
            end else begin
               lk_d.dir = ~lk_q.dir;
               lk_d.bcnt = lk_q.burst_sync[1];
            end
         end
      end
   end

   // Link registers kept across frames
   always_ff @(posedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         lk_q <= '0;
      end else begin
         lk_q <= lk_d;
      end
   end

   // Frame registers
   // shift register clears
   always_ff @(posedge sclk_i or posedge frame_rst) begin
      if (frame_rst) begin
         fr_q <= '0;
      end else begin
         fr_q <= fr_d;
      end
   end

   // Output bit launched on falling edges; reset to the leading zero so a
   // select falling with the clock low already shows the MSB
   // MSB at select fall
   always_ff @(negedge sclk_i or posedge frame_rst) begin
      if (frame_rst) begin
         out_q <= 1'b0;
      end else begin
         out_q <= st_q.tx[4'(4'hf - fr_q.cnt)];
      end
   end

   // Master clock next state
   always_comb begin
      logic rx_evt;
      logic cs_rise;
      logic [WORD_BITS-1:0] w;
      logic [3:0] addr;
      logic [3:0] sel;
      logic start;
      rx_evt = 1'b0;
      cs_rise = 1'b0;
      w = '0;
      addr = '0;
      sel = '0;
      start = 1'b0;
      st_d = st_q;
      // Pins and link signals pass two flip-flops first
      // crossing into master clock
      st_d.fs_sync = {st_q.fs_sync[0], frame_select_n_i};
      st_d.cs_sync = {st_q.cs_sync[0], conv_start_n_i};
      st_d.cs_last = st_q.cs_sync[1];
      st_d.tgl_sync = {st_q.tgl_sync[0], lk_q.rx_tgl};
      st_d.tgl_last = st_q.tgl_sync[1];
      st_d.dir_sync = {st_q.dir_sync[0], lk_q.dir};
      rx_evt = st_q.tgl_sync[1] ^ st_q.tgl_last;
      cs_rise = st_q.cs_sync[1] & ~st_q.cs_last;
      // The received word stays stable for a whole word time after the toggle
      w = lk_q.rx_word;
      addr = w[WORD_BITS-1:WADDR_LSB];
      start = cs_rise;
      if (rx_evt && w != '0 && addr < ADDR_RESULT) begin
         st_d.regs[addr] = {2'b00, w[WDATA_W-1:0]};
         if (addr == ADDR_CTRL && w[CTRL_START_BIT]) begin
            start = 1'b1;
            st_d.regs[ADDR_CTRL][CTRL_START_BIT] = 1'b0;
         end
      end
      // Conversion and calibration share one down-counter
      // bounded conversion time
      if (st_q.busy) begin
         if (st_q.timer == '0) begin
            st_d.busy = 1'b0;
            st_d.cal = 1'b0;
            if (!st_q.cal) begin
               st_d.regs[ADDR_RESULT] = adc_data_i;
            end
         end else begin
            st_d.timer = st_q.timer - TW'(1);
         end
      end else if (start) begin
         st_d.busy = 1'b1;
         st_d.timer = TW'(CONV_LAST);
      end
      st_d.regs[ADDR_STATUS] = '0;
      st_d.regs[ADDR_STATUS][STAT_BUSY_BIT] = st_d.busy;
      st_d.regs[ADDR_STATUS][STAT_CAL_BIT] = st_d.cal;
      // Read word only changes between frames or right after a word, so the
      // link never sees it move in mid-word
      sel = st_q.regs[ADDR_CTRL][CTRL_SEL_LSB +: 4];
      if (st_q.fs_sync[1] || rx_evt) begin
         st_d.tx = '0;
         if (sel < 4'(REG_COUNT)) begin
            st_d.tx = {2'b00, st_q.regs[sel]};
         end
      end
      st_d.oe_out = ~st_q.fs_sync[1] & ~st_q.regs[ADDR_CTRL][CTRL_TWO_WIRE_BIT];
      st_d.oe_in = ~st_q.fs_sync[1] & st_q.regs[ADDR_CTRL][CTRL_TWO_WIRE_BIT] & st_q.dir_sync[1];
   end

   // Master clock registers; calibration runs straight out of reset
   // power-on calibration
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= '0;
         st_q.fs_sync <= 2'b11;
         st_q.cs_sync <= 2'b11;
         st_q.cs_last <= 1'b1;
         st_q.regs[ADDR_CTRL] <= CTRL_RESET;
         st_q.busy <= 1'b1;
         st_q.cal <= 1'b1;
         st_q.timer <= TW'(CAL_CYCLES - 1);
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from flip-flops
   assign serial_in_o = out_q;
   assign serial_out_o = out_q;
   assign serial_in_oe_o = st_q.oe_in;
   assign serial_out_oe_o = st_q.oe_out;
   assign busy_o = st_q.busy;

   // Word arrival seen on the master clock, used by the checks below
   logic rx_seen;
   logic [3:0] rx_addr;
   assign rx_seen = st_q.tgl_sync[1] ^ st_q.tgl_last;
   assign rx_addr = lk_q.rx_word[WORD_BITS-1:WADDR_LSB];

   // Checks on the master clock
   a_reset_three_wire: assert property (@(posedge clock_i) $fell(rst_i) |->
      !st_q.regs[ADDR_CTRL][CTRL_TWO_WIRE_BIT] && st_q.cal)
      else $error("port not in three-wire calibration after reset");
   a_zero_word_ignored: assert property (@(posedge clock_i) disable iff (rst_i)
      (st_q.tgl_sync[1] ^ st_q.tgl_last) && lk_q.rx_word == '0 |=> $stable(st_q.regs[ADDR_RESULT-1:0]))
      else $error("zero word changed a register");
   a_pin_starts_conv: assert property (@(posedge clock_i) disable iff (rst_i)
      st_q.cs_sync[1] && !st_q.cs_last && !st_q.busy |=> busy_o ##1 busy_o)
      else $error("pin pulse did not start conversion");
   a_conv_time_bound: assert property (@(posedge clock_i) disable iff (rst_i)
      st_q.busy && !st_q.cal |-> st_q.timer <= TW'(CONV_LAST))
      else $error("conversion longer than allowed");
   a_busy_clears: assert property (@(posedge clock_i) disable iff (rst_i)
      st_q.busy && st_q.timer == '0 |=> !busy_o && !st_q.regs[ADDR_STATUS][STAT_BUSY_BIT])
      else $error("busy did not clear at conversion end");
   a_float_while_high: assert property (@(posedge clock_i) disable iff (rst_i)
      st_q.fs_sync[1] |=> !serial_out_oe_o && !serial_in_oe_o)
      else $error("line driven while select high");
   a_three_wire_drive: assert property (@(posedge clock_i) disable iff (rst_i)
      !st_q.fs_sync[1] && !st_q.regs[ADDR_CTRL][CTRL_TWO_WIRE_BIT] |=> serial_out_oe_o && !serial_in_oe_o)
      else $error("three-wire output not enabled in frame");

   // Checks on register writes, conversions and the two-wire line direction
   a_soft_start: assert property (@(posedge clock_i) disable iff (rst_i)
      rx_seen && rx_addr == ADDR_CTRL && lk_q.rx_word[CTRL_START_BIT] && !st_q.busy
      |=> busy_o && !st_q.regs[ADDR_CTRL][CTRL_START_BIT])
      else $error("control start bit did not start conversion");
   a_reg_written: assert property (@(posedge clock_i) disable iff (rst_i)
      rx_seen && lk_q.rx_word != '0 && rx_addr != ADDR_CTRL && rx_addr < ADDR_RESULT
      |=> st_q.regs[rx_addr] == {2'b00, lk_q.rx_word[WDATA_W-1:0]})
      else $error("register write did not land");
   a_high_addr_ignored: assert property (@(posedge clock_i) disable iff (rst_i)
      rx_seen && rx_addr >= ADDR_RESULT |=> $stable(st_q.regs[ADDR_RESULT-1:0]))
      else $error("write to read-only address changed a register");
   a_result_captured: assert property (@(posedge clock_i) disable iff (rst_i)
      st_q.busy && !st_q.cal && st_q.timer == '0 |=> st_q.regs[ADDR_RESULT] == $past(adc_data_i))
      else $error("conversion result not captured");
   a_cal_no_result: assert property (@(posedge clock_i) disable iff (rst_i)
      st_q.busy && st_q.cal && st_q.timer == '0 |=> $stable(st_q.regs[ADDR_RESULT]) && !st_q.cal)
      else $error("calibration end disturbed the result");
   a_line_reverts: assert property (@(posedge clock_i) disable iff (rst_i)
      !st_q.dir_sync[1] |=> !serial_in_oe_o)
      else $error("two-wire line still driven after read word");

   // Checks on the shift clock
   // The next shift-clock edge may come only in the next frame, so select
   // must not cancel these checks; only the system reset does
   a_word_received: assert property (@(posedge sclk_i) disable iff (rst_i)
      word_end && receiving |=> lk_q.rx_word == $past(full_word) && lk_q.rx_tgl != $past(lk_q.rx_tgl))
      else $error("word not delivered on sixteenth edge");
   a_dir_flips: assert property (@(posedge sclk_i) disable iff (rst_i)
      word_end && two_wire && lk_q.bcnt == 3'h0 |=> lk_q.dir != $past(lk_q.dir))
      else $error("direction did not flip at word end");
   a_burst_holds: assert property (@(posedge sclk_i) disable iff (rst_i)
      word_end && two_wire && lk_q.bcnt != 3'h0 |=> $stable(lk_q.dir))
      else $error("direction changed inside burst");
   a_dir_two_wire_only: assert property (@(posedge sclk_i) disable iff (rst_i)
      word_end && !two_wire |=> $stable(lk_q.dir))
      else $error("direction changed in three-wire mode");

   c_conv_done: cover property (@(posedge clock_i) disable iff (rst_i) $fell(busy_o) && !$past(st_q.cal));
   c_two_wire_read: cover property (@(posedge clock_i) disable iff (rst_i) $rose(serial_in_oe_o));
   c_burst_word: cover property (@(posedge sclk_i) disable iff (frame_rst) word_end && lk_q.bcnt != 3'h0);
   c_soft_write: cover property (@(posedge clock_i) disable iff (rst_i)
      (st_q.tgl_sync[1] ^ st_q.tgl_last) && lk_q.rx_word[CTRL_START_BIT]);
   c_pin_start: cover property (@(posedge clock_i) disable iff (rst_i) st_q.cs_sync[1] && !st_q.cs_last && !st_q.busy);
endmodule : asp_top

`default_nettype wire

// ### verification/asp_host_model.sv
// Host serial master model for the converter serial port
`timescale 1ns/1ps
`default_nettype none
module asp_host_model (
   output logic sclk_o,
   output logic frame_select_n_o,
   output logic line_o,
   input wire logic line_i,
   input wire logic serial_out_i,
   input wire logic out_oe_i,
   input wire logic line_oe_i
);
   // idle clock high: a gated clock rests high and only runs inside a frame
   initial begin
      sclk_o = 1'b1;
      frame_select_n_o = 1'b1;
      line_o = 1'b0;
   end

   // separate transfers: on a read word the host lets go of the line
   // Released line shows the inverse of the last bit, so stale data never passes
   task automatic xfer(input logic [15:0] tx, input int nbits, input logic two,
                       output logic [15:0] rx, output logic oe);
      frame_select_n_o = 1'b0;
      #30;
      for (int k = 0; k < nbits; k++) begin
         sclk_o = 1'b0;
         #1;
         line_o = (two && line_oe_i) ? ~line_o : tx[15-k];
         #5;
         sclk_o = 1'b1;
         rx = {rx[14:0], two ? line_i : serial_out_i};
         if (k == 7) oe = two ? line_oe_i : out_oe_i;
         #6;
      end
      // frame reset: select high ends or recovers a word
      frame_select_n_o = 1'b1;
      line_o = ~line_o;
      #60;
   endtask : xfer
endmodule : asp_host_model
`default_nettype wire

// ### verification/asp_top_bench.sv
// Self-checking bench for the two-mode converter serial port
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module asp_top_bench;
   import asp_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic conv_start_n = 1'b1;
   logic [REG_W-1:0] adc_data = 14'h0000;
   logic sclk, fsel_n, host_line, line, dev_line, dev_oe, dout, dout_oe, dout_seen, busy, oe;
   logic [15:0] rx;
   int bad_count = 0;
   int samples_checked = 0;
   int n;

   // Master clock, 5 ns period
   initial begin
      forever #2.5 clock = ~clock;
   end

   // Shared data line: the device wins while it drives
   assign line = dev_oe ? dev_line : host_line;
   // A floating output shows the inverse of its bit, so a late enable cannot pass
   assign dout_seen = dout_oe ? dout : ~dout;

   asp_top #(.CAL_CYCLES(50)) i_asp_top (.clock_i(clock), .rst_i(rst), .sclk_i(sclk), .frame_select_n_i(fsel_n),
      .serial_in_i(line), .serial_in_o(dev_line), .serial_in_oe_o(dev_oe), .serial_out_o(dout),
      .serial_out_oe_o(dout_oe), .conv_start_n_i(conv_start_n), .adc_data_i(adc_data), .busy_o(busy));
   asp_host_model i_asp_host_model (.sclk_o(sclk), .frame_select_n_o(fsel_n), .line_o(host_line),
      .line_i(line), .serial_out_i(dout_seen), .out_oe_i(dout_oe), .line_oe_i(dev_oe));

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run

   task automatic xf(input logic [15:0] tx, input logic two = 1'b0);
      i_asp_host_model.xfer(tx, 16, two, rx, oe);
   endtask : xf

   // Bounded wait on busy; a hang is cut short as a mismatch
   task automatic wait_busy(input logic lvl, input int lim);
      n = 0;
      while (busy !== lvl) begin
         @(negedge clock);
         n++;
         if (n > lim) begin
            bad_count++;
            $display("wait on busy ran out");
            complete_run();
         end
      end
   endtask : wait_busy

   task automatic test_reset();
      `CHK(busy, 1'b1) // calibration busy
      `CHK(dout_oe, 1'b0) // output floats
      rst = 1'b0;
      wait_busy(1'b0, 200);
      `CHK(n >= 45 && n <= 55, 1'b1) // calibration length
      `CHK(dev_oe, 1'b0) // three-wire default
      $display("test reset done");
   endtask : test_reset

   task automatic test_regs();
      xf(16'h0004);
      xf(16'h1abc);
      xf(16'h0000);
      `CHK(rx, 16'h0abc) // register readback
      `CHK(oe, 1'b1) // output enabled in frame
      `CHK(dout_oe, 1'b0) // released after frame
      xf(16'h0000);
      `CHK(rx, 16'h0abc) // zero word harmless
      $display("test regs done");
   endtask : test_regs

   task automatic test_abort();
      i_asp_host_model.xfer(16'h0000, 5, 1'b0, rx, oe);
      xf(16'h1123);
      xf(16'h0000);
      `CHK(rx, 16'h0123) // word restarts
      $display("test abort done");
   endtask : test_abort

   task automatic test_conv_pin();
      xf(16'h0030);
      @(negedge clock);
      adc_data = 14'h1234;
      conv_start_n = 1'b0;
      repeat (4) @(negedge clock);
      conv_start_n = 1'b1;
      wait_busy(1'b1, 10);
      wait_busy(1'b0, 1000);
      `CHK(n >= 695 && n <= 702, 1'b1) // conversion time
      xf(16'hcfff);
      xf(16'h0000);
      `CHK(rx, 16'h1234) // pin start result
      xf(16'h0034);
      xf(16'h0000);
      `CHK(rx[STAT_BUSY_BIT], 1'b0) // busy bit clear
      $display("test conv pin done");
   endtask : test_conv_pin

   task automatic test_conv_soft();
      @(negedge clock);
      adc_data = 14'h2bcd;
      xf(16'h0031);
      wait_busy(1'b1, 20);
      wait_busy(1'b0, 1000);
      xf(16'h0000);
      `CHK(rx, 16'h2bcd) // control bit start
      $display("test conv soft done");
   endtask : test_conv_soft

   // Two-wire words alternate write then read on one line; the mode write
   // itself is a three-wire word, so the first two-wire word is a write
   // no software starts in two-wire mode, conversions there use the pin; the code still starts one on a control start bit write
   task automatic test_two_wire();
      // mode entered by a control write
      xf(16'h0006);
      xf(16'h0000, 1'b1);
      `CHK(oe, 1'b0) // first word is input
      xf(16'h0000, 1'b1);
      `CHK(rx, 16'h0123) // line turns output
      `CHK(oe, 1'b1) // driver enabled
      `CHK(dev_oe, 1'b0) // line reverts
      xf(16'h1a55, 1'b1);
      `CHK(oe, 1'b0) // write word is input
      xf(16'h0000, 1'b1);
      `CHK(rx, 16'h0a55) // pulsed select read
      $display("test two wire done");
   endtask : test_two_wire

   // One extra word per burst: two writes, then two reads, direction held
   task automatic test_burst();
      // control writes keep the two-wire bit
      xf(16'h0046, 1'b1);
      `CHK(oe, 1'b0) // control write is input
      xf(16'h0000, 1'b1);
      `CHK(rx, 16'h0a55) // still two-wire after control write
      xf(16'h1111, 1'b1);
      `CHK(oe, 1'b0) // write burst stays input
      xf(16'h2222, 1'b1);
      `CHK(oe, 1'b0) // write burst stays input
      xf(16'h0000, 1'b1);
      `CHK(rx, 16'h0111) // read burst first word
      `CHK(oe, 1'b1) // read burst stays output
      xf(16'h0000, 1'b1);
      `CHK(rx, 16'h0111) // read burst second word
      `CHK(oe, 1'b1) // read burst stays output
      $display("test burst done");
   endtask : test_burst

   // A second reset in mid-run drops two-wire mode and recalibrates
   task automatic test_reset_again();
      @(negedge clock);
      rst = 1'b1;
      repeat (2) @(negedge clock);
      `CHK(busy, 1'b1) // calibration restarts
      rst = 1'b0;
      wait_busy(1'b0, 200);
      xf(16'h0000);
      `CHK(oe, 1'b1) // three-wire output after reset
      `CHK(dev_oe, 1'b0) // two-wire line released
      `CHK(rx, 16'h0000) // control back to default
      $display("test reset again done");
   endtask : test_reset_again

   // Main sequence: six cycles of reset, then the scenarios
   initial begin
      repeat (6) @(negedge clock);
      test_reset();
      test_regs();
      test_abort();
      test_conv_pin();
      test_conv_soft();
      test_two_wire();
      test_burst();
      test_reset_again();
      complete_run();
   end
endmodule : asp_top_bench
`default_nettype wire
